// >>> psm_controller.v
// power saving mode controller: clock divider, idle, timebase stop, full stop
// assumes clock is the oscillator clock; the cpu core pulses instruction
// strobes and accepts the forced interrupt level and vector requests
//
// How it works
// - after reset run clocks at oscillator divided by two
// - enable bit and select field in misc control
// - reduced clock divides by 4, 8, 16, 32
// - idle while reduced clock gives reduced idle state
// - wait instruction stops cpu, peripherals keep running
// - idle entry forces interrupt level to 10b
// - idle holds until interrupt or reset, then vectors
// - servicing pushes level; core restores on pop
// - stop picks full or timebase stop by enable
// - timebase stop exits on interrupts, no delay
// - timebase stop entry forces level, pending wakes
// - timebase stop runs only oscillator and timebase
// - timebase stop with watchdog gives no reset
// - timebase stop delay only on reset exit
// - full stop exits on interrupt, waits 4096 cycles
// - full stop entry forces level, pending wakes
// - full stop kills oscillator and all clocks
// - watchdog stop option decides reset versus stop
// - opcode 8e decodes as stop instruction
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "psm_consts.vh"
module psm_controller #(
   parameter STAB_OSC_CYCLES = `PSM_STAB_OSC_CYCLES
) (
   // clock and reset
   input  wire        clock,
   input  wire        rst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // cpu core
   input  wire        wfi_exec,
   input  wire        opcode_valid,
   input  wire [7:0]  opcode,
   input  wire        watchdog_active,
   input  wire        watchdog_stop_option,
   input  wire        wake_irq_any,
   input  wire        wake_irq_stop,
   input  wire        timebase_irq,
   output reg         ilvl_force,
   output reg  [1:0]  ilvl_value,
   output reg         wake_service,
   output reg         watchdog_reset_req,
   // clocking
   output reg         cpu_clk_en,
   output reg         periph_clk_en,
   output reg         timebase_clk_en,
   output reg         osc_enable,
   output reg  [2:0]  mode
);

   // ------------------------------------------------------------
   // modes
   // ------------------------------------------------------------
   localparam [2:0] M_RUN      = 3'd0;
   localparam [2:0] M_SLOW     = 3'd1;
   localparam [2:0] M_WAIT     = 3'd2;
   localparam [2:0] M_SLOWWAIT = 3'd3;
   localparam [2:0] M_TBSTOP   = 3'd4;
   localparam [2:0] M_STOP     = 3'd5;
   localparam [2:0] M_STAB     = 3'd6;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg        rc_en_reg;
   reg [1:0]  rc_sel_reg;
   reg        tb_ie_reg;
   reg [2:0]  mode_reg;
   reg [2:0]  mode_next;
   reg [2:0]  div_log2_reg;
   reg [5:0]  div_cnt_reg;
   reg [13:0] stab_cnt_reg;

   wire       apb_wr = psel & penable & pwrite;
   wire       stop_exec = opcode_valid & (opcode == `PSM_STOP_OPCODE);
   wire [5:0] div_last = 6'h3f >> (3'd6 - div_log2_reg);
   wire       div_tick = (div_cnt_reg == div_last);
   wire       in_idle = (mode_reg == M_WAIT) | (mode_reg == M_SLOWWAIT);

   // divider exponent wanted by the current control bits
   function [2:0] want_log2;
      input       en;
      input [1:0] sel;
      begin
         want_log2 = en ? (`PSM_RC_DIV_BASE_LOG2 + {1'b0, sel})
                        : `PSM_RUN_DIV_LOG2;
      end
   endfunction

   // ------------------------------------------------------------
   // apb slave, zero wait states
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         rc_en_reg  <= 1'b0;
         rc_sel_reg <= 2'b00;
         tb_ie_reg  <= 1'b0;
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel & ~penable) begin
            case (paddr)
               `PSM_MISC_CTRL_OFFS:   prdata <= {29'h0, rc_en_reg, rc_sel_reg};
               `PSM_CLK_STATUS_OFFS:  prdata <= {31'h0, tb_ie_reg};
               `PSM_MODE_STATUS_OFFS: prdata <= {24'h0, osc_enable, periph_clk_en,
                                                 cpu_clk_en, (mode_reg == M_STAB), 1'b0,
                                                 mode_reg};
               default:               pslverr <= 1'b1;
            endcase
         end
         if (apb_wr & pready) begin
            if (paddr == `PSM_MISC_CTRL_OFFS) begin
               rc_en_reg  <= pwdata[`PSM_RC_EN_BIT];
               rc_sel_reg <= pwdata[`PSM_RC_SEL_LSB+1:`PSM_RC_SEL_LSB];
            end
            if (paddr == `PSM_CLK_STATUS_OFFS)
               tb_ie_reg <= pwdata[`PSM_TB_IE_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // mode sequencer
   // ------------------------------------------------------------
   always @* begin
      mode_next = mode_reg;
      case (mode_reg)
         M_RUN, M_SLOW: begin
            // with the timebase enabled the watchdog option never blocks a stop
            if (stop_exec & (tb_ie_reg | ~(watchdog_active & watchdog_stop_option)))
               mode_next = tb_ie_reg ? M_TBSTOP : M_STOP;
            else if (wfi_exec)
               mode_next = (mode_reg == M_SLOW) ? M_SLOWWAIT : M_WAIT;
            else
               mode_next = rc_en_reg ? M_SLOW : M_RUN;
         end
         M_WAIT, M_SLOWWAIT: begin
            if (wake_irq_any)
               mode_next = rc_en_reg ? M_SLOW : M_RUN;
         end
         M_TBSTOP: begin
            if (timebase_irq | wake_irq_stop)
               mode_next = rc_en_reg ? M_SLOW : M_RUN;
         end
         M_STOP: begin
            if (wake_irq_stop)
               mode_next = M_STAB;
         end
         M_STAB: begin
            if (stab_cnt_reg == 14'd0)
               mode_next = rc_en_reg ? M_SLOW : M_RUN;
         end
         default: mode_next = M_RUN;
      endcase
   end

   always @(posedge clock) begin
      if (rst) begin
         // reset exit of any stop mode starts with stabilisation in the core
         // reset sequence; here reset lands straight in run
         mode_reg           <= M_RUN;
         div_log2_reg       <= `PSM_RUN_DIV_LOG2;
         div_cnt_reg        <= 6'h00;
         stab_cnt_reg       <= 14'd0;
         ilvl_force         <= 1'b0;
         ilvl_value         <= `PSM_ILVL_ENABLE_ALL;
         wake_service       <= 1'b0;
         watchdog_reset_req <= 1'b0;
         cpu_clk_en         <= 1'b0;
         periph_clk_en      <= 1'b0;
         timebase_clk_en    <= 1'b0;
         osc_enable         <= 1'b1;
         mode               <= M_RUN;
      end else begin
         mode_reg <= mode_next;
         mode     <= mode_next;
         // divide ratio only swaps at the end of a whole divided period
         if (div_tick) begin
            div_cnt_reg  <= 6'h00;
            div_log2_reg <= want_log2(rc_en_reg, rc_sel_reg);
         end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
         end
         // level forced on every idle or stop entry
         ilvl_force <= (mode_next != mode_reg) &
                       ((mode_next == M_WAIT) | (mode_next == M_SLOWWAIT) |
                        (mode_next == M_TBSTOP) | (mode_next == M_STOP));
         ilvl_value <= `PSM_ILVL_ENABLE_ALL;
         // core pushes the level and loads the priority on this strobe
         wake_service <= ((in_idle | (mode_reg == M_TBSTOP)) &
                          ((mode_next == M_RUN) | (mode_next == M_SLOW))) |
                         ((mode_reg == M_STAB) & (mode_next != M_STAB));
         watchdog_reset_req <= (mode_reg == M_RUN | mode_reg == M_SLOW) & stop_exec &
                               watchdog_active & watchdog_stop_option & ~tb_ie_reg;
         if (mode_next == M_STAB && mode_reg != M_STAB) begin
            stab_cnt_reg      <= STAB_OSC_CYCLES[13:0] - 14'd1;
         end else if (stab_cnt_reg != 14'd0) begin
            stab_cnt_reg <= stab_cnt_reg - 14'd1;
         end
         // clock enables follow the sequenced mode
         case (mode_next)
            M_RUN, M_SLOW: begin
               cpu_clk_en      <= div_tick;
               periph_clk_en   <= div_tick;
               timebase_clk_en <= div_tick;
               osc_enable      <= 1'b1;
            end
            M_WAIT, M_SLOWWAIT: begin
               cpu_clk_en      <= 1'b0;
               periph_clk_en   <= div_tick;
               timebase_clk_en <= div_tick;
               osc_enable      <= 1'b1;
            end
            M_TBSTOP: begin
               cpu_clk_en      <= 1'b0;
               periph_clk_en   <= 1'b0;
               timebase_clk_en <= div_tick;
               osc_enable      <= 1'b1;
            end
            M_STOP: begin
               cpu_clk_en      <= 1'b0;
               periph_clk_en   <= 1'b0;
               timebase_clk_en <= 1'b0;
               osc_enable      <= 1'b0;
            end
            default: begin
               cpu_clk_en      <= 1'b0;
               periph_clk_en   <= 1'b0;
               timebase_clk_en <= 1'b0;
               osc_enable      <= 1'b1;
            end
         endcase
      end
   end

endmodule

// >>> psm_consts.vh
// power saving mode controller constants: register map, fields, codes, timing
// assumes inclusion by bare name from the design file
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH
// apb register byte offsets
`define PSM_MISC_CTRL_OFFS     12'h000
`define PSM_CLK_STATUS_OFFS    12'h004
`define PSM_MODE_STATUS_OFFS   12'h008
// misc_control_reg_one fields
`define PSM_RC_EN_BIT          2
`define PSM_RC_SEL_LSB         0
// clock_controller_status_reg fields
`define PSM_TB_IE_BIT          0
// mode status fields
`define PSM_MODE_LSB           0
`define PSM_STAB_BIT           4
`define PSM_CPU_CLK_BIT        5
`define PSM_PER_CLK_BIT        6
`define PSM_OSC_BIT            7
// interrupt level code forced on entry to idle and stop modes
`define PSM_ILVL_ENABLE_ALL    2'b10
// stop opcode
`define PSM_STOP_OPCODE        8'h8e
// run divider and reduced-clock divider exponents
`define PSM_RUN_DIV_LOG2       3'd1
`define PSM_RC_DIV_BASE_LOG2   3'd2
// oscillator stabilisation, in cpu cycles
`define PSM_STAB_CPU_CYCLES    4096
// oscillator stabilisation in oscillator clocks, two per cpu cycle in run mode (division by 2)
`define PSM_STAB_OSC_CYCLES    (`PSM_STAB_CPU_CYCLES * 2)
`endif

// >>> psm_core_model.sv
// cpu core stand-in: issues instruction strobes, mirrors the interrupt level
// assumes the controller clock; each strobe lasts one cycle
`timescale 1ns/1ps
module psm_core_model (
   // clock
   input  logic       clock,
   // controller side
   input  logic       ilvl_force,
   input  logic [1:0] ilvl_value,
   input  logic       wake_service,
   output logic       wfi_exec,
   output logic       opcode_valid,
   output logic [7:0] opcode,
   output logic [1:0] cc_level,
   output logic [1:0] saved_level
);
   initial begin
      wfi_exec = 1'b0;
      opcode_valid = 1'b0;
      opcode = 8'h5a;
      cc_level = 2'b11;
      saved_level = 2'b11;
   end
   // ----
   // level handling; the service routine runs at level 3 here
   // ----
   always @(posedge clock) begin
      if (wake_service) begin
         saved_level <= cc_level;
         cc_level <= 2'b11;
      end else if (ilvl_force) begin
         cc_level <= ilvl_value;
      end
   end
   // opcode bus shows a changed value once the strobe drops
   task exec(input logic is_wfi, input logic [7:0] op);
      @(posedge clock);
      wfi_exec <= is_wfi;
      opcode_valid <= ~is_wfi;
      opcode <= op;
      @(posedge clock);
      wfi_exec <= 1'b0;
      opcode_valid <= 1'b0;
      opcode <= ~op;
   endtask
endmodule

// >>> psm_chk.sv
// checker on the power mode controller ports
// assumes one oscillator clock and synchronous active-high reset
`timescale 1ns/1ps
module psm_chk (
   // clock and reset
   input logic       clock,
   input logic       rst,
   // core side
   input logic       wfi_exec,
   input logic       opcode_valid,
   input logic [7:0] opcode,
   input logic       watchdog_active,
   input logic       wake_irq_stop,
   input logic       timebase_irq,
   input logic       ilvl_force,
   input logic [1:0] ilvl_value,
   input logic       watchdog_reset_req,
   // clocking
   input logic       cpu_clk_en,
   input logic       periph_clk_en,
   input logic       timebase_clk_en,
   input logic       osc_enable,
   input logic [2:0] mode
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // watchdog excluded: it may turn a stop into a reset
   sequence s_stop;
      opcode_valid && opcode == 8'h8e && mode <= 3'd1 && !watchdog_active;
   endsequence
   AST_STOP_ENTRY: assert property (s_stop |=> mode == 3'd4 || mode == 3'd5)
      else $error("stop entry");
   AST_STOP_ILVL: assert property (s_stop |=> ##[0:1] ilvl_force)
      else $error("stop level force");
   AST_ILVL_VALUE: assert property (ilvl_force |-> ilvl_value == 2'b10)
      else $error("forced level");
   AST_WFI_ENTRY: assert property (
      wfi_exec && !opcode_valid && mode <= 3'd1 |=> mode == $past(mode) + 3'd2)
      else $error("wait entry");
   AST_WAIT_CPU: assert property (mode == 3'd2 || mode == 3'd3 |-> !cpu_clk_en)
      else $error("cpu clock in wait");
   AST_TB_CLOCKS: assert property (
      mode == 3'd4 |-> osc_enable && !cpu_clk_en && !periph_clk_en)
      else $error("timebase stop clocks");
   AST_TB_EXIT: assert property (mode == 3'd4 && timebase_irq |=> mode <= 3'd1)
      else $error("timebase stop exit");
   AST_TB_NO_WDG: assert property (mode == 3'd4 |-> !watchdog_reset_req)
      else $error("watchdog reset in timebase stop");
   AST_STOP_OFF: assert property (
      mode == 3'd5 |-> !osc_enable && !cpu_clk_en && !periph_clk_en && !timebase_clk_en)
      else $error("clocks in full stop");
   AST_STOP_HOLD: assert property (mode == 3'd5 && !wake_irq_stop |=> mode == 3'd5)
      else $error("full stop left");
   AST_NO_RUNT: assert property (cpu_clk_en |=> !cpu_clk_en)
      else $error("runt cpu enable");
endmodule
bind psm_controller psm_chk u_psm_chk (.*);

// >>> tb.sv
// self-checking bench for the power mode controller with a core stand-in
// assumes psm_consts.vh on the include path
`timescale 1ns/1ps
`include "psm_consts.vh"
module tb;
   localparam int STAB = 16;
   logic        clock, rst, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        wfi_exec, opcode_valid, ilvl_force, wake_service, watchdog_reset_req;
   logic [7:0]  opcode;
   logic        watchdog_active, watchdog_stop_option, wake_irq_any, wake_irq_stop;
   logic        timebase_irq, cpu_clk_en, periph_clk_en, timebase_clk_en, osc_enable;
   logic [1:0]  ilvl_value, cc_level, saved_level;
   logic [2:0]  mode;
   int          miscompares, checked, p, i, wdg_seen;
   // rows: misc value [11:9], mode [8:6], cpu enable period [5:0]
   logic [11:0] rows [5] = '{12'h002, 12'h844, 12'ha48, 12'hc50, 12'he60};
   psm_controller #(.STAB_OSC_CYCLES(STAB)) u_psm_controller (.*);
   psm_core_model u_psm_core_model (.*);
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) if (watchdog_reset_req === 1'b1) wdg_seen <= wdg_seen + 1;
   // ----
   // tasks
   // ----
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task tick(output int n);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (cpu_clk_en !== 1'b1 && n < 99);
      if (cpu_clk_en !== 1'b1) miscompares++;
   endtask
   task wait_mode(input logic [2:0] m, output int n);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (mode !== m && n < 999);
      if (mode !== m) miscompares++;
   endtask
   task report_and_stop;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #(25 * 8000);
      miscompares++;
      report_and_stop;
   end
   // ----
   // sequence
   // ----
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {watchdog_active, watchdog_stop_option, wake_irq_any, wake_irq_stop} = '0;
      timebase_irq = 1'b0;
      rst = 1'b1;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      chk("mode", 3'd0, mode);
      chk("osc", 1'b1, osc_enable);
      for (i = 0; i < 5; i++) begin
         apb(1'b1, `PSM_MISC_CTRL_OFFS, {29'h0, rows[i][11:9]});
         apb(1'b0, `PSM_MISC_CTRL_OFFS, 32'h0);
         chk("misc", {29'h0, rows[i][11:9]}, rd);
         repeat (3) tick(p);
         chk("period", rows[i][5:0], p);
         chk("mode", rows[i][8:6], mode);
      end
      for (i = 0; i < 2; i++) begin
         u_psm_core_model.exec(1'b1, 8'h00);
         #1;
         chk("wait mode", 3'd3 - i, mode);
         repeat (2) @(posedge clock);
         chk("level", 2'b10, cc_level);
         wake_irq_any <= 1'b1;
         wait_mode(3'd1 - i, p);
         wake_irq_any <= 1'b0;
         repeat (3) @(posedge clock);
         chk("saved level", 2'b10, saved_level);
         apb(1'b1, `PSM_MISC_CTRL_OFFS, 32'h0);
         wait_mode(3'd0, p);
      end
      u_psm_core_model.exec(1'b0, 8'h8f);
      #1;
      chk("other opcode", 3'd0, mode);
      apb(1'b0, 12'h00c, 32'h0);
      chk("slverr", 1'b1, er);
      {watchdog_active, watchdog_stop_option} <= 2'b11;
      u_psm_core_model.exec(1'b0, `PSM_STOP_OPCODE);
      repeat (3) @(posedge clock);
      chk("wdg reset", 1, wdg_seen);
      chk("wdg mode", 3'd0, mode);
      watchdog_stop_option <= 1'b0;
      u_psm_core_model.exec(1'b0, `PSM_STOP_OPCODE);
      #1;
      chk("stop mode", 3'd5, mode);
      chk("stop osc", 1'b0, osc_enable);
      wake_irq_any <= 1'b1;
      repeat (4) @(posedge clock);
      chk("stop hold", 3'd5, mode);
      wake_irq_stop <= 1'b1;
      wait_mode(3'd6, p);
      {wake_irq_any, wake_irq_stop} <= 2'b00;
      wait_mode(3'd0, p);
      chk("stab cycles", STAB, p);
      apb(1'b1, `PSM_CLK_STATUS_OFFS, 32'h1);
      watchdog_stop_option <= 1'b1;
      u_psm_core_model.exec(1'b0, `PSM_STOP_OPCODE);
      #1;
      chk("tb stop", 3'd4, mode);
      chk("tb osc", 1'b1, osc_enable);
      chk("tb periph", 1'b0, periph_clk_en);
      apb(1'b0, `PSM_MODE_STATUS_OFFS, 32'h0);
      chk("tb status", 32'h0000_0084, rd);
      repeat (3) @(posedge clock);
      chk("tb wdg", 1, wdg_seen);
      timebase_irq <= 1'b1;
      wait_mode(3'd0, p);
      timebase_irq <= 1'b0;
      chk("tb exit", 2, p);
      report_and_stop;
   end
endmodule
